// ---- rtl/rcs_cause.sv ----
// time-out and power-down flag update logic
`timescale 1ns/1ns
module rcs_cause (
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_n,
  input  wire rcs_pkg::rcs_cause_t i_cause,
  output logic                 o_timeout,
  output logic                 o_powerdown
);
  logic next_timeout;
  logic next_powerdown;
  always_comb begin
    next_timeout   = o_timeout;
    next_powerdown = o_powerdown;
    case (i_cause)
      // RQ3: pin reset keeps
      rcs_pkg::RCS_CAUSE_PIN_RUN: begin
        next_timeout   = o_timeout;
        next_powerdown = o_powerdown;
      end
      // RQ4: pin wake flags
      rcs_pkg::RCS_CAUSE_PIN_WAKE: begin
        next_timeout   = 1'b1;
        next_powerdown = 1'b0;
      end
      // RQ5: watchdog run flags
      rcs_pkg::RCS_CAUSE_WDT_RUN: begin
        next_timeout = 1'b0;
      end
      // RQ6: watchdog wake flags
      rcs_pkg::RCS_CAUSE_WDT_WAKE: begin
        next_timeout   = 1'b0;
        next_powerdown = 1'b0;
      end
      // RQ7: pin change wake
      rcs_pkg::RCS_CAUSE_CHG_WAKE: begin
        next_timeout   = 1'b1;
        next_powerdown = 1'b0;
      end
      // RQ8: watchdog clear sets
      rcs_pkg::RCS_CAUSE_WDT_CLR: begin
        next_timeout   = 1'b1;
        next_powerdown = 1'b1;
      end
      // RQ9: sleep entry flags
      rcs_pkg::RCS_CAUSE_SLEEP: begin
        next_timeout   = 1'b1;
        next_powerdown = 1'b0;
      end
      default: begin
        next_timeout   = o_timeout;
        next_powerdown = o_powerdown;
      end
    endcase
  end
  // RQ2: power-on sets both
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timeout   <= 1'b1;
      o_powerdown <= 1'b1;
    end else begin
      o_timeout   <= next_timeout;
      o_powerdown <= next_powerdown;
    end
  end
endmodule : rcs_cause

// ---- rtl/rcs_pkg.sv ----
// constants for the reset cause and initial value block
package rcs_pkg;
  localparam logic [3:0] ADDR_INDIRECT   = 4'h0;
  localparam logic [3:0] ADDR_BANK       = 4'h1;
  localparam logic [3:0] ADDR_PC_LOW     = 4'h2;
  localparam logic [3:0] ADDR_STATUS     = 4'h3;
  localparam logic [3:0] ADDR_FILE_PTR   = 4'h4;
  localparam logic [3:0] ADDR_PORT_A     = 4'h5;
  localparam logic [3:0] ADDR_PORT_B     = 4'h6;
  localparam logic [3:0] ADDR_PORT_C     = 4'h7;
  localparam logic [3:0] ADDR_PORT_D     = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h9;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'hA;
  localparam logic [3:0] ADDR_DIR_A      = 4'hB;
  localparam logic [3:0] ADDR_DIR_B      = 4'hC;
  localparam logic [3:0] ADDR_DIR_C      = 4'hD;
  localparam logic [3:0] ADDR_OP_MODE    = 4'hE;
  localparam logic [3:0] ADDR_EDGE_SEL   = 4'hF;
  // status register bit positions
  localparam int ST_TIMEOUT   = 4;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_INT       = 7;
  // write masks of implemented bits, then register reset values
  localparam logic [7:0] BANK_MASK   = 8'h10;
  localparam logic [7:0] STATUS_WMSK = 8'h87;
  localparam logic [7:0] PORT_D_MASK = 8'h3F;
  localparam logic [7:0] OPMODE_MASK = 8'hC3;
  localparam logic [7:0] EDGE_MASK   = 8'h08;
  localparam logic [7:0] DIR_RESET   = 8'hFF;
  localparam logic [7:0] OPMODE_RST  = 8'hC0;
  localparam logic [7:0] EDGE_RST    = 8'h08;
  localparam logic [7:0] ZERO8       = 8'h00;
  // event bits of the interrupt status register
  localparam int EV_POWER_ON = 0;
  localparam int EV_PIN      = 1;
  localparam int EV_WDT      = 2;
  localparam int EV_PCHANGE  = 3;
  localparam int EV_NUM      = 4;
  typedef enum logic [1:0] {RCS_RUN = 2'b00, RCS_SLEEP = 2'b01, RCS_IDLE = 2'b10} rcs_mode_t;
  typedef enum logic [2:0] {
    RCS_CAUSE_NONE = 3'h0, RCS_CAUSE_PIN_RUN = 3'h1, RCS_CAUSE_PIN_WAKE = 3'h2,
    RCS_CAUSE_WDT_RUN = 3'h3, RCS_CAUSE_WDT_WAKE = 3'h4, RCS_CAUSE_CHG_WAKE = 3'h5,
    RCS_CAUSE_WDT_CLR = 3'h6, RCS_CAUSE_SLEEP = 3'h7
  } rcs_cause_t;
endpackage : rcs_pkg

// ---- rtl/rcs_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module rcs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_idle,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;
  // reset values are constants; idle level taken only as a tie-off shape
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= '1;
      o_sync <= '1;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
  logic unused_idle;
  assign unused_idle = ^i_idle;
endmodule : rcs_sync

// ---- rtl/rcs_top.sv ----
// reset cause recorder and core register initial values
// What this block does
// RQ1: reset on power-on, pin pulse, watchdog
// RQ2: power-on sets time-out and power-down
// RQ3: pin reset while running keeps flags
// RQ4: pin wake: time-out 1, power-down 0
// RQ5: watchdog while running clears time-out
// RQ6: watchdog wake clears both flags
// RQ7: pin-change wake: time-out 1, power-down 0
// RQ8: watchdog clear instruction sets both flags
// RQ9: sleep: time-out 1, power-down 0
// RQ10: resets clear pc, bank, ports; directions input
// RQ11: wake keeps ports, pc, pointers, mode bits
// RQ12: pin/watchdog reset keep pointer and arith flags
// RQ13: flags stay stable while firmware reads
`timescale 1ns/1ns
module rcs_top #(
  parameter int DATA_W = 8
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_reset_pin_n,
  input  wire logic              i_pin_change,
  input  wire logic              i_wdt_timeout,
  input  wire logic              i_watchdog_clear_instruction,
  input  wire logic              i_sleep_instruction,
  input  wire logic              i_idle_enter,
  input  wire logic [3:0]        i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_core_reset,
  output logic                   o_sleeping,
  output logic                   o_irq,
  output logic      [DATA_W-1:0] o_port_a_direction,
  output logic      [DATA_W-1:0] o_port_b_direction,
  output logic      [DATA_W-1:0] o_port_c_direction
);
  logic [1:0] pins_sync;
  logic       pin_low;
  logic       chg_s;
  logic       pin_low_d;
  logic       pin_pulse_end;
  rcs_pkg::rcs_mode_t  mode;
  rcs_pkg::rcs_mode_t  next_mode;
  rcs_pkg::rcs_cause_t cause;
  logic       timeout_flag;
  logic       powerdown_flag;
  logic       warm_reset;
  logic [7:0] indirect_access;
  logic [7:0] bank_select;
  logic [7:0] program_counter_low;
  logic [7:0] core_arith;
  logic [7:0] file_pointer;
  logic [7:0] port_data [4];
  logic [7:0] port_dir [3];
  logic [7:0] operating_mode_control;
  logic [7:0] ext_int_edge_select;
  logic [rcs_pkg::EV_NUM-1:0] irq_status;
  logic [rcs_pkg::EV_NUM-1:0] irq_mask;
  logic [rcs_pkg::EV_NUM-1:0] ev_set;
  logic       powered;
  logic [7:0] core_status;
  logic [7:0] next_rdata;
  logic       wr_status;
  logic       wr_bank;
  logic       wr_indirect;
  logic       wr_pc;
  logic       wr_file_ptr;
  logic       wr_op_mode;
  logic       wr_edge_sel;
  logic       wr_irq_status;
  logic       wr_irq_mask;
  logic       asleep;

  // pin change enters inverted so both stages reset to their idle level
  rcs_sync #(.WIDTH(2)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_reset_pin_n, ~i_pin_change}),
    .i_idle    (2'b11),
    .o_sync    (pins_sync)
  );
  assign pin_low = ~pins_sync[1];
  assign chg_s   = ~pins_sync[0];
  // RQ1: high-low-high pulse ends reset
  assign pin_pulse_end = pin_low_d & ~pin_low;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_low_d <= 1'b0;
    end else begin
      pin_low_d <= pin_low;
    end
  end

  // cause selection; a reset event outranks firmware instructions
  assign asleep = (mode != rcs_pkg::RCS_RUN);
  assign cause =
    (pin_pulse_end && asleep)        ? rcs_pkg::RCS_CAUSE_PIN_WAKE :
    pin_pulse_end                    ? rcs_pkg::RCS_CAUSE_PIN_RUN :
    (i_wdt_timeout && asleep)        ? rcs_pkg::RCS_CAUSE_WDT_WAKE :
    i_wdt_timeout                    ? rcs_pkg::RCS_CAUSE_WDT_RUN :
    (chg_s && asleep)                ? rcs_pkg::RCS_CAUSE_CHG_WAKE :
    i_watchdog_clear_instruction     ? rcs_pkg::RCS_CAUSE_WDT_CLR :
    (i_sleep_instruction && !asleep) ? rcs_pkg::RCS_CAUSE_SLEEP :
                                       rcs_pkg::RCS_CAUSE_NONE;
  // RQ1: pin or watchdog warm reset
  assign warm_reset = pin_pulse_end | i_wdt_timeout;

  // RQ13: flags change only on events
  rcs_cause u_cause (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_cause     (cause),
    .o_timeout   (timeout_flag),
    .o_powerdown (powerdown_flag)
  );

  always_comb begin
    next_mode = mode;
    case (mode)
      // a warm reset in the same cycle wins over a sleep or idle request
      rcs_pkg::RCS_RUN: begin
        if (i_sleep_instruction && !warm_reset) begin
          next_mode = rcs_pkg::RCS_SLEEP;
        end else if (i_idle_enter && !warm_reset) begin
          next_mode = rcs_pkg::RCS_IDLE;
        end
      end
      rcs_pkg::RCS_SLEEP, rcs_pkg::RCS_IDLE: begin
        if (warm_reset || chg_s) begin
          next_mode = rcs_pkg::RCS_RUN;
        end
      end
      default: begin
        next_mode = rcs_pkg::RCS_RUN;
      end
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= rcs_pkg::RCS_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  assign wr_status = i_wr && i_addr == rcs_pkg::ADDR_STATUS;
  assign wr_bank   = i_wr && i_addr == rcs_pkg::ADDR_BANK;
  assign wr_indirect   = i_wr && i_addr == rcs_pkg::ADDR_INDIRECT;
  assign wr_pc         = i_wr && i_addr == rcs_pkg::ADDR_PC_LOW;
  assign wr_file_ptr   = i_wr && i_addr == rcs_pkg::ADDR_FILE_PTR;
  assign wr_op_mode    = i_wr && i_addr == rcs_pkg::ADDR_OP_MODE;
  assign wr_edge_sel   = i_wr && i_addr == rcs_pkg::ADDR_EDGE_SEL;
  assign wr_irq_status = i_wr && i_addr == rcs_pkg::ADDR_IRQ_STATUS;
  assign wr_irq_mask   = i_wr && i_addr == rcs_pkg::ADDR_IRQ_MASK;

  // RQ12: pointers undefined at power-on, kept on warm reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      indirect_access <= rcs_pkg::ZERO8;
      file_pointer    <= rcs_pkg::ZERO8;
      core_arith      <= rcs_pkg::ZERO8;
    end else begin
      if (wr_indirect) begin
        indirect_access <= i_wdata;
      end
      if (wr_file_ptr) begin
        file_pointer <= i_wdata;
      end
      // a warm reset drops the interrupt enable but keeps the arithmetic flags
      if (warm_reset) begin
        core_arith[rcs_pkg::ST_INT] <= 1'b0;
      end else if (wr_status) begin
        core_arith <= i_wdata & rcs_pkg::STATUS_WMSK;
      end
    end
  end

  // RQ10: warm reset clears pc and bank
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bank_select         <= rcs_pkg::ZERO8;
      program_counter_low <= rcs_pkg::ZERO8;
    end else if (warm_reset) begin
      bank_select         <= rcs_pkg::ZERO8;
      program_counter_low <= rcs_pkg::ZERO8;
    end else begin
      // RQ11: wake leaves these untouched
      if (wr_bank) begin
        bank_select <= i_wdata & rcs_pkg::BANK_MASK;
      end
      if (wr_pc) begin
        program_counter_low <= i_wdata;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_port
      localparam logic [3:0] PADDR = rcs_pkg::ADDR_PORT_A + 4'(g);
      localparam logic [7:0] PMASK = (g == 3) ? rcs_pkg::PORT_D_MASK : 8'hFF;
      // RQ10: ports cleared on reset
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          port_data[g] <= rcs_pkg::ZERO8;
        end else if (warm_reset) begin
          port_data[g] <= rcs_pkg::ZERO8;
        end else if (i_wr && i_addr == PADDR) begin
          port_data[g] <= i_wdata & PMASK;
        end
      end
    end
    for (g = 0; g < 3; g++) begin : g_dir
      localparam logic [3:0] DADDR = rcs_pkg::ADDR_DIR_A + 4'(g);
      // RQ10: directions back to input
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          port_dir[g] <= rcs_pkg::DIR_RESET;
        end else if (warm_reset) begin
          port_dir[g] <= rcs_pkg::DIR_RESET;
        end else if (i_wr && i_addr == DADDR) begin
          port_dir[g] <= i_wdata;
        end
      end
    end
  endgenerate

  // RQ11: mode and edge bits kept on wake
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      operating_mode_control <= rcs_pkg::OPMODE_RST;
      ext_int_edge_select    <= rcs_pkg::EDGE_RST;
    end else if (warm_reset) begin
      operating_mode_control <= rcs_pkg::OPMODE_RST;
      ext_int_edge_select    <= rcs_pkg::EDGE_RST;
    end else begin
      if (wr_op_mode) begin
        operating_mode_control <= i_wdata & rcs_pkg::OPMODE_MASK;
      end
      if (wr_edge_sel) begin
        ext_int_edge_select <= i_wdata & rcs_pkg::EDGE_MASK;
      end
    end
  end

  // power-on event fires once after release, caught by a clocked stage
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      powered <= 1'b0;
    end else begin
      powered <= 1'b1;
    end
  end
  assign ev_set[rcs_pkg::EV_POWER_ON] = ~powered;
  assign ev_set[rcs_pkg::EV_PIN]      = pin_pulse_end;
  assign ev_set[rcs_pkg::EV_WDT]      = i_wdt_timeout;
  // a change while running is not a wake and sets nothing
  assign ev_set[rcs_pkg::EV_PCHANGE]  = chg_s & asleep;

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      if (wr_irq_status) begin
        irq_status <= (irq_status & ~i_wdata[rcs_pkg::EV_NUM-1:0]) | ev_set;
      end else begin
        irq_status <= irq_status | ev_set;
      end
      if (wr_irq_mask) begin
        irq_mask <= i_wdata[rcs_pkg::EV_NUM-1:0];
      end
    end
  end
  assign o_irq = |(irq_status & irq_mask);

  assign core_status = {core_arith[rcs_pkg::ST_INT], 2'b00, timeout_flag, powerdown_flag, core_arith[2:0]};

  // RQ13: read returns registered flags
  always_comb begin
    if (i_addr == rcs_pkg::ADDR_INDIRECT) begin
      next_rdata = indirect_access;
    end else if (i_addr == rcs_pkg::ADDR_BANK) begin
      next_rdata = bank_select;
    end else if (i_addr == rcs_pkg::ADDR_PC_LOW) begin
      next_rdata = program_counter_low;
    end else if (i_addr == rcs_pkg::ADDR_STATUS) begin
      next_rdata = core_status;
    end else if (i_addr == rcs_pkg::ADDR_FILE_PTR) begin
      next_rdata = file_pointer;
    end else if (i_addr == rcs_pkg::ADDR_PORT_A) begin
      next_rdata = port_data[0];
    end else if (i_addr == rcs_pkg::ADDR_PORT_B) begin
      next_rdata = port_data[1];
    end else if (i_addr == rcs_pkg::ADDR_PORT_C) begin
      next_rdata = port_data[2];
    end else if (i_addr == rcs_pkg::ADDR_PORT_D) begin
      next_rdata = port_data[3];
    end else if (i_addr == rcs_pkg::ADDR_IRQ_STATUS) begin
      next_rdata = {4'h0, irq_status};
    end else if (i_addr == rcs_pkg::ADDR_IRQ_MASK) begin
      next_rdata = {4'h0, irq_mask};
    end else if (i_addr == rcs_pkg::ADDR_DIR_A) begin
      next_rdata = port_dir[0];
    end else if (i_addr == rcs_pkg::ADDR_DIR_B) begin
      next_rdata = port_dir[1];
    end else if (i_addr == rcs_pkg::ADDR_DIR_C) begin
      next_rdata = port_dir[2];
    end else if (i_addr == rcs_pkg::ADDR_OP_MODE) begin
      next_rdata = operating_mode_control;
    end else begin
      next_rdata = ext_int_edge_select;
    end
  end
  // zero outside the read slot, so a stale word is never taken for data
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= '0;
    end
  end

  // RQ1: core reset pulse to the processor
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_reset <= 1'b1;
    end else begin
      o_core_reset <= warm_reset | pin_low;
    end
  end
  assign o_sleeping         = asleep;
  assign o_port_a_direction = port_dir[0];
  assign o_port_b_direction = port_dir[1];
  assign o_port_c_direction = port_dir[2];
endmodule : rcs_top

// ---- tb/rcs_fw_model.sv ----
// firmware side model: register cycles on the core bus
`timescale 1ns/1ns
module rcs_fw_model (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [3:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
  endtask : wr
  // firmware polls twice back to back, so a flag that drifts shows up
  task automatic rd(input logic [3:0] a, output logic [7:0] d0, output logic [7:0] d1);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    d0 = i_rdata;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    @(negedge i_sys_clk);
    d1 = i_rdata;
  endtask : rd
endmodule : rcs_fw_model

// ---- tb/rcs_props.sv ----
// port assertions for the reset cause block
`timescale 1ns/1ns
module rcs_props #(
  parameter int DATA_W = 8
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst_n,
  input wire logic              i_reset_pin_n,
  input wire logic              i_pin_change,
  input wire logic              i_wdt_timeout,
  input wire logic              i_watchdog_clear_instruction,
  input wire logic              i_sleep_instruction,
  input wire logic              i_idle_enter,
  input wire logic [3:0]        i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              o_core_reset,
  input wire logic              o_sleeping,
  input wire logic              o_irq,
  input wire logic [DATA_W-1:0] o_port_a_direction,
  input wire logic [DATA_W-1:0] o_port_b_direction,
  input wire logic [DATA_W-1:0] o_port_c_direction
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic st_rd;
  wire logic quiet;
  wire logic no_reset;
  wire logic dirs_in;
  assign st_rd = i_rd && (i_addr == rcs_pkg::ADDR_STATUS);
  // no event may land between two polls, else the flags may rightly move
  assign quiet = !i_wdt_timeout && !i_watchdog_clear_instruction && !i_sleep_instruction && !o_core_reset;
  assign no_reset = !i_wdt_timeout && !o_core_reset;
  assign dirs_in = &o_port_a_direction && &o_port_b_direction && &o_port_c_direction;

  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside its slot");
  a_flags_stable: assert property ((st_rd && quiet) ##1 (st_rd && quiet) |=> o_rdata[4:3] == $past(o_rdata[4:3]))
    else $error("flags moved between two polls");
  a_pin_reset: assert property (!i_reset_pin_n [*5] |-> o_core_reset)
    else $error("pin low without core reset");
  a_wdt_reset: assert property (i_wdt_timeout |-> ##[1:2] o_core_reset)
    else $error("watchdog without core reset");
  a_dir_input: assert property (i_wdt_timeout |-> ##3 dirs_in)
    else $error("directions not input after reset");
  a_sleep_enter: assert property (i_sleep_instruction && !o_sleeping && no_reset |=> o_sleeping)
    else $error("sleep not entered");
  a_idle_enter: assert property (i_idle_enter && !o_sleeping && no_reset |=> o_sleeping)
    else $error("idle not entered");
  a_change_wake: assert property (o_sleeping && i_pin_change |-> ##[1:5] !o_sleeping)
    else $error("pin change did not wake");
  a_wdt_wake: assert property (o_sleeping && i_wdt_timeout |-> ##[1:3] !o_sleeping)
    else $error("watchdog did not wake");
endmodule : rcs_props

bind rcs_top rcs_props #(.DATA_W(DATA_W)) u_props (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reset_pin_n(i_reset_pin_n), .i_pin_change(i_pin_change),
  .i_wdt_timeout(i_wdt_timeout), .i_watchdog_clear_instruction(i_watchdog_clear_instruction),
  .i_sleep_instruction(i_sleep_instruction), .i_idle_enter(i_idle_enter), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_core_reset(o_core_reset), .o_sleeping(o_sleeping),
  .o_irq(o_irq), .o_port_a_direction(o_port_a_direction), .o_port_b_direction(o_port_b_direction),
  .o_port_c_direction(o_port_c_direction)
);

// ---- tb/testbench.sv ----
// self-checking bench for the reset cause block
`timescale 1ns/1ns
module testbench;
  logic       clk;
  logic       rst_n;
  logic       pin_n;
  logic       chg;
  logic       wdt;
  logic       clr;
  logic       slp;
  logic       idl;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       sleeping;
  logic       irq;
  logic [7:0] dir_a;
  logic [7:0] dir_b;
  logic [7:0] dir_c;
  logic [7:0] w [16];
  int         fail_count;
  int         samples_checked;

  always #20 clk = ~clk;

  rcs_top #(.DATA_W(8)) u_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_reset_pin_n(pin_n), .i_pin_change(chg), .i_wdt_timeout(wdt),
    .i_watchdog_clear_instruction(clr), .i_sleep_instruction(slp), .i_idle_enter(idl), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_core_reset(), .o_sleeping(sleeping),
    .o_irq(irq), .o_port_a_direction(dir_a), .o_port_b_direction(dir_b), .o_port_c_direction(dir_c)
  );
  rcs_fw_model u_fw (.i_sys_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  function automatic logic [7:0] rst_val(input logic [3:0] a);
    if (a inside {rcs_pkg::ADDR_DIR_A, rcs_pkg::ADDR_DIR_B, rcs_pkg::ADDR_DIR_C}) return 8'hFF;
    if (a == rcs_pkg::ADDR_OP_MODE) return 8'hC0;
    if (a == rcs_pkg::ADDR_EDGE_SEL) return 8'h08;
    return 8'h00;
  endfunction : rst_val
  // only the bank bit and six port d pins exist
  function automatic logic [7:0] keep_val(input logic [3:0] a, input logic [7:0] d);
    if (a == rcs_pkg::ADDR_BANK) return d & 8'h10;
    if (a == rcs_pkg::ADDR_PORT_D) return d & 8'h3F;
    return d;
  endfunction : keep_val
  function automatic logic [7:0] tp(input logic t, input logic p);
    return {3'h0, t, p, 3'h0};
  endfunction : tp

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d0;
    logic [7:0] d1;
    u_fw.rd(a, d0, d1);
    samples_checked++;
    if ((d0 & m) !== e || (d1 & m) !== e) begin
      fail_count++;
      $display("wrong value at %0t: reg %h read %h %h want %h", $time, a, d0, d1, e);
    end
  endtask : chk
  task automatic flags(input logic t, input logic p);
    chk(rcs_pkg::ADDR_STATUS, 8'h18, tp(t, p));
  endtask : flags
  // waits past the edge, then samples; k picks 0 sleeping, 1 irq, 2 all directions input
  task automatic cmp(input int k, input logic e);
    logic g;
    repeat (2) @(negedge clk);
    g = (k == 0) ? sleeping : (k == 1) ? irq : (dir_a === 8'hFF && dir_b === 8'hFF && dir_c === 8'hFF);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: check %0d got %b want %b", $time, k, g, e);
    end
  endtask : cmp
  task automatic ev(input int k);
    @(posedge clk);
    wdt <= (k == 0);
    clr <= (k == 1);
    slp <= (k == 2);
    idl <= (k == 3);
    @(posedge clk);
    {wdt, clr, slp, idl} <= 4'h0;
    repeat (6) @(posedge clk);
  endtask : ev
  task automatic pin_pulse;
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    pin_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : pin_pulse
  task automatic wake;
    @(posedge clk);
    chg <= 1'b1;
    repeat (4) @(posedge clk);
    chg <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : wake

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    pin_n = 1'b1;
    {chg, wdt, clr, slp, idl} = 5'h00;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(32'hE9D2CDA8));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    flags(1'b1, 1'b1);
    for (int a = 1; a < 16; a++) begin
      if (!(a inside {3, 4, 9, 10})) chk(4'(a), 8'hFF, rst_val(4'(a)));
    end
    cmp(2, 1'b1);
    $display("test power-on done");
    for (int a = 1; a < 14; a++) begin
      w[a] = 8'($urandom);
      if (!(a inside {3, 9, 10})) u_fw.wr(4'(a), w[a]);
    end
    ev(1);
    flags(1'b1, 1'b1);
    ev(2);
    cmp(0, 1'b1);
    flags(1'b1, 1'b0);
    wake();
    cmp(0, 1'b0);
    flags(1'b1, 1'b0);
    ev(3);
    cmp(0, 1'b1);
    wake();
    for (int a = 1; a < 14; a++) begin
      if (!(a inside {3, 9, 10})) chk(4'(a), 8'hFF, keep_val(4'(a), w[a]));
    end
    $display("test sleep and idle done");
    ev(1);
    flags(1'b1, 1'b1);
    ev(0);
    flags(1'b0, 1'b1);
    for (int a = 1; a < 14; a++) begin
      if (!(a inside {3, 9, 10})) chk(4'(a), 8'hFF, (a == 4) ? w[4] : rst_val(4'(a)));
    end
    pin_pulse();
    flags(1'b0, 1'b1);
    chk(rcs_pkg::ADDR_IRQ_STATUS, 8'h0F, 8'h0F);
    $display("test warm resets done");
    ev(2);
    pin_pulse();
    cmp(0, 1'b0);
    flags(1'b1, 1'b0);
    ev(2);
    ev(0);
    cmp(0, 1'b0);
    flags(1'b0, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    flags(1'b1, 1'b1);
    chk(rcs_pkg::ADDR_IRQ_STATUS, 8'h0F, 8'h01);
    $display("test wake resets done");
    u_fw.wr(rcs_pkg::ADDR_IRQ_STATUS, 8'h0F);
    u_fw.wr(rcs_pkg::ADDR_IRQ_MASK, 8'h08);
    cmp(1, 1'b0);
    ev(2);
    wake();
    cmp(1, 1'b1);
    chk(rcs_pkg::ADDR_IRQ_STATUS, 8'h0F, 8'h08);
    u_fw.wr(rcs_pkg::ADDR_IRQ_MASK, 8'h00);
    cmp(1, 1'b0);
    u_fw.wr(rcs_pkg::ADDR_IRQ_MASK, 8'h08);
    cmp(1, 1'b1);
    u_fw.wr(rcs_pkg::ADDR_IRQ_STATUS, 8'h08);
    cmp(1, 1'b0);
    u_fw.wr(rcs_pkg::ADDR_BANK, 8'hFF);
    chk(rcs_pkg::ADDR_BANK, 8'hFF, 8'h10);
    $display("test interrupt done");
    finish_test();
  end
endmodule : testbench
